/* File: logic/mics_map.vh */
// Purpose: register map, field positions, reset values and timing for the mac interface block
// Assumes: one 16-bit register on a 32-bit apb bus, index times four gives the byte address
// Notes: strap bits take their reset value from pins after reset release
// Functional notes
// - bit 12 set delays rgmii receive clock 3.5ns; clear keeps edges aligned.
// - bit 11 inverted: 1 disables transmit clock delay, 0 enables 3.5ns delay.
// - bit 10 set means phy and mac share one clock reference.
// - bit 9 set selects rgmii whatever bit 5 holds.
// - without rgmii, bit 5 selects rmii when 1, mii when 0.
// - bit 8 enables the rmii transmit path clock shift.
// - bit 7 expects a 50 MHz reference when 1, 25 MHz when 0.
// - rgmii mode and clock select reset from straps; software may override later.
// - rmii with bit 6 at 0 bypasses receive fifo, 50 MHz on rx clock.
// - bit 4 at 1 holds crs_dv high until the last data leaves.
// - bit 4 at 0 toggles crs_dv at packet end after carrier drops.
// - bit 3 flags receive fifo overflow, cleared by reading the register.
// - bit 2 flags receive fifo underflow, cleared by reading the register.
// - size field 00/01/10/11 gives 14/2/6/10 bits of tolerance, reset 01.
`ifndef MICS_MAP_VH
`define MICS_MAP_VH
`define MICS_REG_INDEX 10'h017
`define MICS_REG_ADDR ({`MICS_REG_INDEX, 2'b00})
`define MICS_B_RX_SHIFT 12
`define MICS_B_TX_SHIFT 11
`define MICS_B_TX_SYNC 10
`define MICS_B_RGMII 9
`define MICS_B_RMII_TXS 8
`define MICS_B_CLK50 7
`define MICS_B_FIFO_NRM 6
`define MICS_B_RMII 5
`define MICS_B_REV10 4
`define MICS_B_OVF 3
`define MICS_B_UNF 2
`define MICS_RW_MASK 16'h1FF3
`define MICS_RESET_VAL 16'h0041
`define MICS_CLK_DELAY_PS 3500
`define MICS_POP_DIV 8
`endif

/* File: logic/mics_top.v */
// Purpose: mac interface configuration and status register with rmii receive elasticity buffer
// Assumes: apb slave on pclk, link clock sampled as a plain input through two flip-flops
// Notes: no wait state on any transfer; buffer holds dibits, tolerance counted in bits
//
// Local design decision: the APB register port.
`include "mics_map.vh"
module mics_top #(
   parameter PW = 4,
   parameter POP_DIV = `MICS_POP_DIV
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire rgmii_mode_strap,
   input wire ref_clock_frequency_strap,
   input wire link_clk,
   input wire link_crs_dv,
   input wire [1:0] link_rxd,
   output reg mode_rgmii,
   output reg mode_rmii,
   output reg mode_mii,
   output reg rgmii_rx_delay_en,
   output reg rgmii_tx_delay_en,
   output reg rgmii_tx_synced,
   output reg rmii_tx_shift_en,
   output reg ref_clk_50m_sel,
   output reg rx_fifo_bypass,
   output reg rx_clk_out_50m,
   output reg mac_crs_dv,
   output reg [1:0] mac_rxd
);
   localparam DEPTH = 1 << PW;
   localparam [PW:0] FULL = DEPTH;
   localparam [7:0] POP_LAST = POP_DIV - 1;

   // start threshold in dibits for each tolerance setting
   function [PW:0] start_level;
      input [1:0] sz;
      reg [31:0] lvl;
      begin
         case (sz)
            2'b00: lvl = 32'h0000_0007;
            2'b01: lvl = 32'h0000_0001;
            2'b10: lvl = 32'h0000_0003;
            default: lvl = 32'h0000_0005;
         endcase
         start_level = lvl[PW:0];
      end
   endfunction

   reg [15:0] cfg_r;
   reg ovf_r;
   reg unf_r;
   reg [1:0] strap_age_r;
   reg [1:0] strap_rg_r;
   reg [1:0] strap_xi_r;
   reg [2:0] lclk_r;
   reg [1:0] ldv_r;
   reg [1:0] lrxd0_r;
   reg [1:0] lrxd1_r;
   reg [1:0] mem_r [0:DEPTH-1];
   reg [PW-1:0] wr_ptr_r;
   reg [PW-1:0] rd_ptr_r;
   // one bit wider than the pointers so that full and empty differ
   reg [PW:0] count_r;
   reg frame_r;
   reg started_r;
   reg [7:0] div_r;
   reg pop_en_r;
   reg [15:0] rd_val;
   reg [15:0] wr_val;
   integer i;

   wire hit = (paddr[11:2] == `MICS_REG_INDEX);
   wire setup = psel & ~penable;
   wire done = psel & penable & pready;
   wire wr_hit = done & pwrite & hit;
   wire rd_hit = done & ~pwrite & hit;
   wire sel_rgmii = cfg_r[`MICS_B_RGMII];
   wire sel_rmii = ~sel_rgmii & cfg_r[`MICS_B_RMII];
   wire bypass = sel_rmii & ~cfg_r[`MICS_B_FIFO_NRM];
   wire link_rise = lclk_r[1] & ~lclk_r[2];
   wire push = sel_rmii & ~bypass & link_rise & ldv_r[1];
   wire full = (count_r == FULL);
   wire empty = (count_r == {(PW+1){1'b0}});
   wire do_push = push & ~full;
   wire do_pop = pop_en_r & started_r & ~empty;
   wire ovf_evt = push & full;
   wire unf_evt = pop_en_r & started_r & empty & frame_r;

   // only a flag that the read returned is cleared, so a later event is not lost
   wire clr_ovf = rd_hit & prdata[`MICS_B_OVF];
   wire clr_unf = rd_hit & prdata[`MICS_B_UNF];
   wire strap_load = (strap_age_r != 2'b11);

   always @* begin
      rd_val = cfg_r & `MICS_RW_MASK;
      rd_val[`MICS_B_OVF] = ovf_r;
      rd_val[`MICS_B_UNF] = unf_r;
      wr_val = cfg_r;
      if (pstrb[0]) begin
         wr_val[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
         wr_val[15:8] = pwdata[15:8];
      end
      wr_val = wr_val & `MICS_RW_MASK;
   end

   // apb slave: answer registered in the setup cycle, completes in the next
   // read data is a snapshot taken at the setup edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= ~hit;
            prdata <= (hit & ~pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
         end else if (done) begin
            pslverr <= 1'b0;
         end
      end
   end

   // straps pass two flip-flops; the third edge after release loads the synced pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_rg_r <= 2'b00;
         strap_xi_r <= 2'b00;
         strap_age_r <= 2'b00;
      end else begin
         strap_rg_r <= {strap_rg_r[0], rgmii_mode_strap};
         strap_xi_r <= {strap_xi_r[0], ref_clock_frequency_strap};
         if (strap_load) begin
            strap_age_r <= strap_age_r + 2'b01;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= `MICS_RESET_VAL;
      end else if (strap_load) begin
         cfg_r[`MICS_B_RGMII] <= strap_rg_r[1];
         cfg_r[`MICS_B_CLK50] <= strap_xi_r[1];
      end else if (wr_hit) begin
         cfg_r <= wr_val;
      end
   end

   // sticky status: an event in the clearing cycle wins
   // clear is tied to the snapshot, not to the flag's present value
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_r <= 1'b0;
         unf_r <= 1'b0;
      end else begin
         if (ovf_evt) begin
            ovf_r <= 1'b1;
         end else if (clr_ovf) begin
            ovf_r <= 1'b0;
         end
         if (unf_evt) begin
            unf_r <= 1'b1;
         end else if (clr_unf) begin
            unf_r <= 1'b0;
         end
      end
   end

   // configuration outputs
   // transmit shift bit has inverted sense: a one turns the delay off
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_rgmii <= 1'b0;
         mode_rmii <= 1'b0;
         mode_mii <= 1'b0;
         rgmii_rx_delay_en <= 1'b0;
         rgmii_tx_delay_en <= 1'b0;
         rgmii_tx_synced <= 1'b0;
         rmii_tx_shift_en <= 1'b0;
         ref_clk_50m_sel <= 1'b0;
         rx_fifo_bypass <= 1'b0;
         rx_clk_out_50m <= 1'b0;
      end else begin
         mode_rgmii <= sel_rgmii;
         mode_rmii <= sel_rmii;
         mode_mii <= ~sel_rgmii & ~cfg_r[`MICS_B_RMII];
         rgmii_rx_delay_en <= sel_rgmii & cfg_r[`MICS_B_RX_SHIFT];
         rgmii_tx_delay_en <= sel_rgmii & ~cfg_r[`MICS_B_TX_SHIFT];
         rgmii_tx_synced <= sel_rgmii & cfg_r[`MICS_B_TX_SYNC];
         rmii_tx_shift_en <= sel_rmii & cfg_r[`MICS_B_RMII_TXS];
         ref_clk_50m_sel <= cfg_r[`MICS_B_CLK50];
         rx_fifo_bypass <= bypass;
         rx_clk_out_50m <= bypass;
      end
   end

   // link inputs through two flip-flops; third stage only for edge detect
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lclk_r <= 3'b000;
         ldv_r <= 2'b00;
         lrxd0_r <= 2'b00;
         lrxd1_r <= 2'b00;
      end else begin
         lclk_r <= {lclk_r[1:0], link_clk};
         ldv_r <= {ldv_r[0], link_crs_dv};
         lrxd0_r <= {lrxd0_r[0], link_rxd[0]};
         lrxd1_r <= {lrxd1_r[0], link_rxd[1]};
      end
   end

   // local rmii clock rate as one-cycle enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 8'h00;
         pop_en_r <= 1'b0;
      end else if (div_r == POP_LAST) begin
         div_r <= 8'h00;
         pop_en_r <= 1'b1;
      end else begin
         div_r <= div_r + 8'h01;
         pop_en_r <= 1'b0;
      end
   end

   // elasticity buffer absorbs rate offset between link and local clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= {PW{1'b0}};
         rd_ptr_r <= {PW{1'b0}};
         count_r <= {(PW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= 2'b00;
         end
      end else begin
         if (do_push) begin
            mem_r[wr_ptr_r] <= {lrxd1_r[1], lrxd0_r[1]};
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (do_push & ~do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop & ~do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

   // frame tracking and output timing to the mac
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_r <= 1'b0;
         started_r <= 1'b0;
         mac_crs_dv <= 1'b0;
         mac_rxd <= 2'b00;
      end else if (bypass) begin
         frame_r <= 1'b0;
         started_r <= 1'b0;
         if (link_rise) begin
            mac_crs_dv <= ldv_r[1];
            mac_rxd <= {lrxd1_r[1], lrxd0_r[1]};
         end
      end else if (!sel_rmii) begin
         frame_r <= 1'b0;
         started_r <= 1'b0;
         mac_crs_dv <= 1'b0;
         mac_rxd <= 2'b00;
      end else begin
         if (link_rise) begin
            frame_r <= ldv_r[1];
         end
         if (!started_r && count_r >= start_level(cfg_r[1:0])) begin
            started_r <= 1'b1;
         end else if (started_r && empty && !frame_r) begin
            started_r <= 1'b0;
         end
         if (do_pop) begin
            mac_rxd <= mem_r[rd_ptr_r];
            if (cfg_r[`MICS_B_REV10] || frame_r) begin
               mac_crs_dv <= 1'b1;
            end else begin
               mac_crs_dv <= ~mac_crs_dv;
            end
         end else if (pop_en_r && !(started_r && frame_r)) begin
            mac_crs_dv <= 1'b0;
            mac_rxd <= 2'b00;
         end
      end
   end
endmodule

/* File: bench/mics_checker.sv */
// Purpose: port-level checks for the mac interface register block
// Assumes: no wait state in any apb transfer, register at word index 0x17
// Notes: bound to the design top from the bench top
module mics_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire mode_rgmii,
   input wire mode_rmii,
   input wire mode_mii,
   input wire rgmii_rx_delay_en,
   input wire rgmii_tx_delay_en,
   input wire rgmii_tx_synced,
   input wire rmii_tx_shift_en,
   input wire rx_fifo_bypass,
   input wire rx_clk_out_50m
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup = psel && !penable;
   wire hit = paddr[11:2] == 10'h017;
   a_ready_after_setup: assert property (setup |=> pready ##1 !pready)
      else $error("pready is not a one-cycle answer to setup");
   a_err_unmapped: assert property (setup && !hit |=> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (setup && hit |=> !pslverr)
      else $error("error on the mapped register");
   a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read data not zero");
   a_reserved_zero: assert property (pready && !pwrite |-> prdata[31:13] == '0)
      else $error("reserved read bits not zero");
   a_rgmii_alone: assert property (mode_rgmii |-> !mode_rmii && !mode_mii)
      else $error("rgmii not exclusive");
   a_rmii_alone: assert property (mode_rmii |-> !mode_mii && !mode_rgmii)
      else $error("rmii not exclusive");
   a_rgmii_gates: assert property (!mode_rgmii |-> !(rgmii_rx_delay_en || rgmii_tx_delay_en || rgmii_tx_synced))
      else $error("rgmii controls active outside rgmii");
   a_bypass_rmii: assert property (rx_fifo_bypass |-> mode_rmii && rx_clk_out_50m)
      else $error("bypass outside rmii or without 50 MHz clock");
   a_shift_rmii: assert property (rmii_tx_shift_en |-> mode_rmii)
      else $error("rmii transmit shift outside rmii");
   c_error: cover property (pready && pslverr);
   c_tx_delay: cover property (mode_rgmii && rgmii_tx_delay_en);
   c_bypass: cover property (rx_fifo_bypass);
endmodule

/* File: bench/mics_link_model.sv */
// Purpose: receive side of the link as seen by the block
// Assumes: data changes on the falling link clock edge
// Notes: link clock stands still low between frames
module mics_link_model (
   output logic link_clk,
   output logic link_crs_dv,
   output logic [1:0] link_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      link_clk = 0;
      link_crs_dv = 0;
      link_rxd = 2'h0;
   end
   // a stall in mid-frame stands for clock offset the buffer must absorb
   task automatic frame(input int n, input int stall);
      #($urandom_range(49));
      for (int i = 0; i < n; i++) begin
         link_crs_dv = 1;
         link_rxd = 2'($urandom);
         #200 link_clk = 1;
         #200 link_clk = 0;
         if (i == n / 2) #(stall * 400);
      end
      link_crs_dv = 0;
      // released data line shows the inverse, not the last value
      link_rxd = ~link_rxd;
      #200 link_clk = 1;
      #200 link_clk = 0;
   endtask
endmodule

/* File: bench/mics_top_tb.sv */
// Purpose: self-checking bench for the mac interface register block
// Assumes: apb master leaves one idle cycle between transfers
// Notes: link frames come from mics_link_model
`include "mics_map.vh"
module mics_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, cd_q = 0;
   logic rgmii_mode_strap = 0, ref_clock_frequency_strap = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic [15:0] w;
   logic [15:0] cfg [3] = '{16'h0070, 16'h0060, 16'h0030};
   logic pready, pslverr, link_clk, link_crs_dv, mac_crs_dv;
   logic [1:0] link_rxd, mac_rxd;
   logic mode_rgmii, mode_rmii, mode_mii, rgmii_rx_delay_en, rgmii_tx_delay_en;
   logic rgmii_tx_synced, rmii_tx_shift_en, ref_clk_50m_sel, rx_fifo_bypass, rx_clk_out_50m;
   int mismatches = 0, n_compared = 0, falls = 0;
   // pops slower than the link so that a long frame overflows the buffer
   mics_top #(.POP_DIV(9)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .rgmii_mode_strap, .ref_clock_frequency_strap,
      .link_clk, .link_crs_dv, .link_rxd, .mode_rgmii, .mode_rmii, .mode_mii, .rgmii_rx_delay_en,
      .rgmii_tx_delay_en, .rgmii_tx_synced, .rmii_tx_shift_en, .ref_clk_50m_sel,
      .rx_fifo_bypass, .rx_clk_out_50m, .mac_crs_dv, .mac_rxd);
   mics_link_model u_link (.link_clk, .link_crs_dv, .link_rxd);
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (cd_q && !mac_crs_dv) falls++;
      cd_q <= mac_crs_dv;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   function automatic logic [9:0] exp_out(input logic [15:0] v);
      logic g, m;
      g = v[9];
      m = !v[9] && v[5];
      return {g, m, !g && !v[5], g && v[12], g && !v[11], g && v[10], m && v[8], v[7],
         m && !v[6], m && !v[6]};
   endfunction
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #1_000_000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(78640));
      for (int i = 0; i < 2; i++) begin
         rgmii_mode_strap <= i[0];
         ref_clock_frequency_strap <= !i[0];
         presetn <= 0;
         repeat (3) @(posedge pclk);
         presetn <= 1;
         // straps settle through the synchroniser before the first access
         repeat (3) @(posedge pclk);
         apb(0, `MICS_REG_ADDR, 0);
         chk(rd, {22'h0, i[0], 1'b0, !i[0], 7'h41}, "reset value");
      end
      for (int i = 0; i < 8; i++) begin
         w = i == 0 ? 16'hffff : i == 1 ? 16'h0000 : 16'($urandom);
         apb(1, `MICS_REG_ADDR, w);
         apb(0, `MICS_REG_ADDR, 0);
         chk(rd, {16'h0000, w & `MICS_RW_MASK}, "readback");
         chk({mode_rgmii, mode_rmii, mode_mii, rgmii_rx_delay_en, rgmii_tx_delay_en,
            rgmii_tx_synced, rmii_tx_shift_en, ref_clk_50m_sel, rx_fifo_bypass,
            rx_clk_out_50m}, exp_out(w), "mode outputs");
      end
      apb(1, 12'h058, 16'hffff);
      apb(0, 12'h058, 0);
      chk({e, rd[30:0]}, 32'h8000_0000, "unmapped read");
      apb(0, `MICS_REG_ADDR, 0);
      chk(rd, {16'h0000, w & `MICS_RW_MASK}, "after unmapped write");
      foreach (cfg[k]) begin
         apb(1, `MICS_REG_ADDR, cfg[k]);
         falls = 0;
         u_link.frame(24, 0);
         repeat (200) @(posedge pclk);
         chk({falls > 1, falls > 0}, {k == 1, 1'b1}, "carrier drops");
      end
      apb(1, `MICS_REG_ADDR, 16'h0061);
      apb(0, `MICS_REG_ADDR, 0);
      u_link.frame(12, 20);
      repeat (200) @(posedge pclk);
      apb(0, `MICS_REG_ADDR, 0);
      chk(rd[2], 1, "underflow flag");
      u_link.frame(200, 0);
      repeat (400) @(posedge pclk);
      apb(0, `MICS_REG_ADDR, 0);
      chk(rd[3:2], 2'b10, "overflow flag");
      apb(0, `MICS_REG_ADDR, 0);
      chk(rd[3:2], 0, "status after read");
      tally_and_finish();
   end
endmodule
bind mics_top mics_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .mode_rgmii, .mode_rmii, .mode_mii, .rgmii_rx_delay_en,
   .rgmii_tx_delay_en, .rgmii_tx_synced, .rmii_tx_shift_en, .rx_fifo_bypass, .rx_clk_out_50m);
